// file: logic/scs_pkg.sv
// Shared types and constants for the sync check and source sensing block
package scs_pkg;

  // ----------------------------------------------------------------
  // Units: voltage 0.1 % of nominal, angle 0.1 deg, frequency 0.01 Hz
  // ----------------------------------------------------------------
  localparam int VW = 12;
  localparam int AW = 12;
  localparam int FW = 16;
  localparam int TW = 16;
  localparam int PW = 17;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
  localparam logic [PW-1:0] TICK_DIV_DEFAULT = PW'(TICK_CYCLES);
  localparam int HOLD_RESET_MS  = 5000;
  localparam logic [TW-1:0] HOLD_RESET_TICKS =
    TW'(HOLD_RESET_MS * 1000 / TICK_US);

  // ----------------------------------------------------------------
  // Fixed angle limits
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] PHASE_CLOSE_LIMIT = 12'h064;
  localparam logic [AW-1:0] LL_ANGLE_NOMINAL  = 12'h4b0;
  localparam logic [AW-1:0] LL_ANGLE_TOL      = 12'h12c;

  // ----------------------------------------------------------------
  // Window reset values
  // ----------------------------------------------------------------
  localparam logic [VW-1:0] VOLT_WIN_DEFAULT  = 12'h032;
  localparam logic [AW-1:0] PHASE_WIN_DEFAULT = 12'h064;
  localparam logic [FW-1:0] FREQ_WIN_DEFAULT  = 16'h0064;
  localparam logic [TW-1:0] TIME_WIN_DEFAULT  = 16'h01f4;
  localparam logic [VW-1:0] DEAD_BUS_DEFAULT  = 12'h0fa;

  // ----------------------------------------------------------------
  // Sensor indices
  // ----------------------------------------------------------------
  localparam int SEN_UV  = 0;
  localparam int SEN_OV  = 1;
  localparam int SEN_FRQ = 2;
  localparam int SEN_LOP = 3;
  localparam int NSEN    = 4;
  localparam int BUS_GEN = 0;
  localparam int BUS_UTL = 1;

  typedef struct packed {
    logic [2:0][VW-1:0] volt;
    logic [FW-1:0]      freq;
    logic               rot;
    logic [2:0][AW-1:0] ll_angle;
  } scs_bus_s;

  typedef struct packed {
    logic [VW-1:0] volt;
    logic [AW-1:0] phase;
    logic [FW-1:0] freq;
    logic [TW-1:0] time_ticks;
    logic [VW-1:0] dead_utl;
    logic [VW-1:0] dead_gen;
  } scs_window_s;

  typedef struct packed {
    logic [VW-1:0]     uv_drop;
    logic [VW-1:0]     uv_pick;
    logic [VW-1:0]     ov_drop;
    logic [VW-1:0]     ov_pick;
    logic [FW-1:0]     f_lo_drop;
    logic [FW-1:0]     f_hi_drop;
    logic [FW-1:0]     f_lo_pick;
    logic [FW-1:0]     f_hi_pick;
    logic [NSEN-1:0][TW-1:0] delay;
    logic              en_ov;
    logic              en_frq;
    logic              en_rot;
    logic              en_lop;
  } scs_sens_cfg_s;

  typedef enum logic [1:0] {
    HOLD_IDLE  = 2'b00,
    HOLD_PRESS = 2'b01,
    HOLD_FLASH = 2'b11,
    HOLD_WAIT  = 2'b10
  } scs_hold_e;

endpackage : scs_pkg

// file: logic/scs_sensor.sv
// One delayed-dropout, immediate-pickup source sensor
`timescale 1ns/1ps
module scs_sensor
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  // Timing
  input  wire logic          tick_in,
  input  wire logic [TW-1:0] delay_in,
  // Conditions
  input  wire logic          enable_in,
  input  wire logic          drop_cond_in,
  input  wire logic          pick_cond_in,
  // Result
  output logic               picked_out
);

  logic [TW-1:0] count;
  logic          picked;

  // A disabled sensor never blocks availability
  assign picked_out = picked | ~enable_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      picked <= 1'b0;
      count  <= '0;
    end else if (picked) begin
      if (!drop_cond_in) begin
        count <= '0;
      end else if (count >= delay_in) begin
        picked <= 1'b0;
        count  <= '0;
      end else if (tick_in) begin
        count <= count + 1'b1;
      end
    end else if (pick_cond_in) begin
      picked <= 1'b1;
    end
  end

endmodule : scs_sensor

// file: logic/scs_sync_check.sv
// Sync check permissive, source availability and discrete I/O logic
`timescale 1ns/1ps
// Operation
// - Live-bus permissive only while both utility and genset are available
// - Live-bus permissive needs equal measured rotation on both buses
// - Largest per-phase voltage difference must be below voltage window
// - Phase below window and falling, or below window and 10 degrees
// - Absolute frequency difference must be below frequency window
// - All criteria must hold for the time window; any failure restarts
// - Permissive drops at once when any criterion fails
// - Sync-only: enables for dead/dead, live utility/dead, dead/live genset
// - Separate dead-bus thresholds per bus, default 25 percent nominal
// - Source available only while every enabled sensor is picked up
// - Undervoltage always on: delayed dropout, immediate pickup
// - Overvoltage when enabled: delayed dropout, immediate pickup
// - Frequency when enabled: delayed dropout outside limits, pickup inside
// - Rotation sensor drops when source rotation differs from setting
// - Loss of phase drops after delay when angle is more than 30 off 120
// - Auto runs when sources good; enable switch acts only in Manual
// - Fault reset acknowledges and clears latched faults
// - Holding reset over 5 s enters flash-out; a brief press leaves
// - Discrete inputs active when grounded; mode active means Manual
// - Sinks one, two, seven: common warning, fail-to-sync, output limit
// - Sinks three, four, six: genset ok, utility ok, sync check ok
// - Sink eight stays on while healthy, off on hardware failure
// - Windows adjustable: defaults 5 percent, 10 deg, 0.5 s, 1.0 Hz
// - Sync check runs regardless of whether synchronizing is active
module scs_sync_check
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  // Measurements
  input  wire logic          meas_valid_in,
  input  wire scs_bus_s      gen_meas_in,
  input  wire scs_bus_s      utl_meas_in,
  input  wire logic [AW-1:0] phase_diff_in,
  // Configuration
  input  wire logic [PW-1:0] tick_div_in,
  input  wire logic          win_load_in,
  input  wire scs_window_s   win_in,
  input  wire scs_sens_cfg_s gen_cfg_in,
  input  wire scs_sens_cfg_s utl_cfg_in,
  input  wire logic          sys_rot_in,
  input  wire logic          sync_only_in,
  input  wire logic [2:0]    dead_en_in,
  input  wire logic [TW-1:0] fail_time_in,
  input  wire logic          lockout_en_in,
  // Events from other logic
  input  wire logic          output_limit_in,
  input  wire logic          hw_fail_in,
  // Discrete pins, active low
  input  wire logic          fault_reset_n_in,
  input  wire logic          manual_n_in,
  input  wire logic          sync_enable_n_in,
  // Status
  output logic               permissive_out,
  output logic               sync_run_out,
  output logic               flash_mode_out,
  output logic               manual_mode_out,
  // Low-side sinks, high means driver on
  output logic               warning_sink_drive_out,
  output logic               sync_fail_sink_drive_out,
  output logic               genset_ok_sink_drive_out,
  output logic               mains_ok_sink_drive_out,
  output logic               in_sync_sink_drive_out,
  output logic               bias_limit_sink_drive_out,
  output logic               health_sink_drive_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [VW-1:0] max3(input logic [2:0][VW-1:0] v);
    logic [VW-1:0] m;
    m = (v[0] > v[1]) ? v[0] : v[1];
    return (m > v[2]) ? m : v[2];
  endfunction : max3

  function automatic logic [VW-1:0] min3(input logic [2:0][VW-1:0] v);
    logic [VW-1:0] m;
    m = (v[0] < v[1]) ? v[0] : v[1];
    return (m < v[2]) ? m : v[2];
  endfunction : min3

  function automatic logic [FW-1:0] absdiff(input logic [FW-1:0] a,
                                            input logic [FW-1:0] b);
    return (a > b) ? FW'(a - b) : FW'(b - a);
  endfunction : absdiff

  function automatic logic angle_bad(input logic [AW-1:0] a);
    return absdiff(FW'(a), FW'(LL_ANGLE_NOMINAL)) > FW'(LL_ANGLE_TOL);
  endfunction : angle_bad

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      pin_meta <= {fault_reset_n_in, manual_n_in, sync_enable_n_in};
      pin_sync <= pin_meta;
    end
  end
  wire logic reset_pressed = ~pin_sync[2];
  wire logic manual_mode   = ~pin_sync[1];
  wire logic sync_switch   = ~pin_sync[0];

  // ----------------------------------------------------------------
  // Tick prescaler
  // ----------------------------------------------------------------
  logic [PW-1:0] tick_count;
  logic          tick;
  wire  logic    tick_wrap = tick_count + 1'b1 >= tick_div_in;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else begin
      tick_count <= tick_wrap ? '0 : tick_count + 1'b1;
      tick       <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Measurement capture and window settings
  // ----------------------------------------------------------------
  scs_bus_s      gen;
  scs_bus_s      utl;
  logic [AW-1:0] phase_abs;
  logic [AW-1:0] phase_prev;
  scs_window_s   win;
  wire  logic    phase_neg = phase_diff_in[AW-1];
  wire  logic [AW-1:0] next_phase_abs =
    phase_neg ? AW'(-phase_diff_in) : phase_diff_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      gen        <= '0;
      utl        <= '0;
      phase_abs  <= '1;
      phase_prev <= '1;
    end else if (meas_valid_in) begin
      gen        <= gen_meas_in;
      utl        <= utl_meas_in;
      phase_prev <= phase_abs;
      phase_abs  <= next_phase_abs;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      win <= '{volt: VOLT_WIN_DEFAULT, phase: PHASE_WIN_DEFAULT,
               freq: FREQ_WIN_DEFAULT, time_ticks: TIME_WIN_DEFAULT,
               dead_utl: DEAD_BUS_DEFAULT,
               dead_gen: DEAD_BUS_DEFAULT};
    end else if (win_load_in) begin
      win <= win_in;
    end
  end

  // ----------------------------------------------------------------
  // Source sensors
  // ----------------------------------------------------------------
  scs_bus_s      bus   [2];
  scs_sens_cfg_s cfg   [2];
  logic [NSEN-1:0] picked [2];
  logic [1:0]    avail;
  assign bus[BUS_GEN] = gen;
  assign bus[BUS_UTL] = utl;
  assign cfg[BUS_GEN] = gen_cfg_in;
  assign cfg[BUS_UTL] = utl_cfg_in;

  for (genvar b = 0; b < 2; b++) begin : g_bus
    wire logic [VW-1:0] vmin = min3(bus[b].volt);
    wire logic [VW-1:0] vmax = max3(bus[b].volt);
    wire logic [FW-1:0] f    = bus[b].freq;
    wire logic [NSEN-1:0] drop;
    wire logic [NSEN-1:0] pick;
    wire logic [NSEN-1:0] en;
    wire logic lop_bad = angle_bad(bus[b].ll_angle[0]) |
                         angle_bad(bus[b].ll_angle[1]) |
                         angle_bad(bus[b].ll_angle[2]);
    assign drop[SEN_UV]  = vmin < cfg[b].uv_drop;
    assign pick[SEN_UV]  = vmin > cfg[b].uv_pick;
    assign drop[SEN_OV]  = vmax > cfg[b].ov_drop;
    assign pick[SEN_OV]  = vmax < cfg[b].ov_pick;
    assign drop[SEN_FRQ] = f < cfg[b].f_lo_drop |
                           f > cfg[b].f_hi_drop;
    assign pick[SEN_FRQ] = f >= cfg[b].f_lo_pick &
                           f <= cfg[b].f_hi_pick;
    assign drop[SEN_LOP] = lop_bad;
    assign pick[SEN_LOP] = ~lop_bad;
    assign en = {cfg[b].en_lop, cfg[b].en_frq, cfg[b].en_ov, 1'b1};

    for (genvar s = 0; s < NSEN; s++) begin : g_sen
      scs_sensor u_sensor (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .tick_in      (tick),
        .delay_in     (cfg[b].delay[s]),
        .enable_in    (en[s]),
        .drop_cond_in (drop[s]),
        .pick_cond_in (pick[s]),
        .picked_out   (picked[b][s])
      );
    end

    // Rotation has no delay: a wrong rotation is never transient
    wire logic rot_ok = ~cfg[b].en_rot |
                        (bus[b].rot == sys_rot_in);
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        avail[b] <= 1'b0;
      end else begin
        avail[b] <= &picked[b] & rot_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync check criteria
  // ----------------------------------------------------------------
  wire logic [2:0][VW-1:0] vdiff;
  for (genvar p = 0; p < 3; p++) begin : g_vd
    assign vdiff[p] = VW'(absdiff(FW'(gen.volt[p]), FW'(utl.volt[p])));
  end
  wire logic both_avail = avail[BUS_GEN] & avail[BUS_UTL];
  wire logic rot_match  = gen.rot == utl.rot;
  wire logic volt_ok    = max3(vdiff) < win.volt;
  wire logic phase_in   = phase_abs < win.phase;
  wire logic phase_ok   = phase_in &
    (phase_abs < phase_prev | phase_abs < PHASE_CLOSE_LIMIT);
  wire logic freq_ok    = absdiff(gen.freq, utl.freq) < win.freq;
  wire logic live_ok    = both_avail & rot_match & volt_ok &
                          phase_ok & freq_ok;

  // Dead-bus close only in sync-only use
  wire logic utl_dead = max3(utl.volt) < win.dead_utl;
  wire logic gen_dead = max3(gen.volt) < win.dead_gen;
  wire logic dead_ok  = sync_only_in & (
    (dead_en_in[0] & utl_dead & gen_dead) |
    (dead_en_in[1] & avail[BUS_UTL] & gen_dead) |
    (dead_en_in[2] & utl_dead & avail[BUS_GEN]));
  wire logic crit_ok  = live_ok | dead_ok;

  // Runs whether or not synchronizing is on
  logic [TW-1:0] win_count;
  logic          permissive;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      win_count  <= '0;
      permissive <= 1'b0;
    end else if (!crit_ok) begin
      win_count  <= '0;
      permissive <= 1'b0;
    end else if (win_count >= win.time_ticks) begin
      permissive <= 1'b1;
    end else if (tick) begin
      win_count <= win_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fault reset and flash-out mode
  // ----------------------------------------------------------------
  scs_hold_e     hold_state;
  scs_hold_e     next_hold_state;
  logic [TW-1:0] hold_count;
  logic          press_prev;
  wire  logic    press_edge = reset_pressed & ~press_prev;

  always_comb begin
    next_hold_state = hold_state;
    case (hold_state)
      HOLD_IDLE:  if (reset_pressed) next_hold_state = HOLD_PRESS;
      HOLD_PRESS: begin
        if (!reset_pressed) begin
          next_hold_state = HOLD_IDLE;
        end else if (hold_count >= HOLD_RESET_TICKS) begin
          next_hold_state = HOLD_FLASH;
        end
      end
      HOLD_FLASH: if (press_edge) next_hold_state = HOLD_WAIT;
      HOLD_WAIT:  if (!reset_pressed) next_hold_state = HOLD_IDLE;
      default:    next_hold_state = HOLD_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      hold_state <= HOLD_IDLE;
      hold_count <= '0;
      press_prev <= 1'b0;
    end else begin
      hold_state <= next_hold_state;
      press_prev <= reset_pressed;
      if (hold_state != HOLD_PRESS) begin
        hold_count <= '0;
      end else if (tick) begin
        hold_count <= hold_count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronizer run and latched faults
  // ----------------------------------------------------------------
  logic          fail_sync;
  logic          rot_warn;
  logic          limit_warn;
  logic          sync_run;
  logic [TW-1:0] fail_count;
  wire  logic    mode_ok  = ~manual_mode | sync_switch;
  wire  logic    next_run = both_avail & mode_ok & rot_match &
                            ~(fail_sync & lockout_en_in);
  wire  logic    fail_hit = sync_run & ~permissive &
                            fail_count >= fail_time_in;

  // A new event in the clearing cycle keeps its flag set
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fail_sync  <= 1'b0;
      rot_warn   <= 1'b0;
      limit_warn <= 1'b0;
    end else begin
      fail_sync  <= fail_hit | (fail_sync & ~press_edge);
      rot_warn   <= (both_avail & ~rot_match) |
                    (rot_warn & ~press_edge);
      limit_warn <= output_limit_in |
                    (limit_warn & ~press_edge);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sync_run   <= 1'b0;
      fail_count <= '0;
    end else begin
      sync_run <= next_run;
      if (!sync_run || permissive) begin
        fail_count <= '0;
      end else if (tick && !fail_hit) begin
        fail_count <= fail_count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      permissive_out            <= 1'b0;
      sync_run_out              <= 1'b0;
      flash_mode_out            <= 1'b0;
      manual_mode_out           <= 1'b0;
      warning_sink_drive_out    <= 1'b0;
      sync_fail_sink_drive_out  <= 1'b0;
      genset_ok_sink_drive_out  <= 1'b0;
      mains_ok_sink_drive_out   <= 1'b0;
      in_sync_sink_drive_out    <= 1'b0;
      bias_limit_sink_drive_out <= 1'b0;
      health_sink_drive_out     <= 1'b0;
    end else begin
      permissive_out            <= permissive;
      sync_run_out              <= sync_run;
      flash_mode_out            <= hold_state == HOLD_FLASH;
      manual_mode_out           <= manual_mode;
      warning_sink_drive_out    <= fail_sync | rot_warn |
                                   limit_warn;
      sync_fail_sink_drive_out  <= fail_sync;
      bias_limit_sink_drive_out <= limit_warn;
      genset_ok_sink_drive_out  <= avail[BUS_GEN];
      mains_ok_sink_drive_out   <= avail[BUS_UTL];
      in_sync_sink_drive_out    <= permissive;
      health_sink_drive_out     <= ~hw_fail_in;
    end
  end

endmodule : scs_sync_check

// file: verification/scs_sync_check_properties.sv
// Port-level assertions for the sync check block
`timescale 1ns/1ps
module scs_sync_check_properties
  import scs_pkg::*;
(
  // Inputs
  input wire logic     clock_in,
  input wire logic     reset_in,
  input wire logic     meas_valid_in,
  input wire scs_bus_s gen_meas_in,
  input wire scs_bus_s utl_meas_in,
  input wire logic     sync_only_in,
  input wire logic     output_limit_in,
  input wire logic     hw_fail_in,
  input wire logic     manual_n_in,
  input wire logic     sync_enable_n_in,
  // Outputs
  input wire logic     permissive_out,
  input wire logic     sync_run_out,
  input wire logic     flash_mode_out,
  input wire logic     manual_mode_out,
  input wire logic     warning_sink_drive_out,
  input wire logic     bias_limit_sink_drive_out,
  input wire logic     genset_ok_sink_drive_out,
  input wire logic     mains_ok_sink_drive_out,
  input wire logic     in_sync_sink_drive_out,
  input wire logic     health_sink_drive_out
);
  wire both_ok = genset_ok_sink_drive_out && mains_ok_sink_drive_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_health_follow: assert property (
    !$past(reset_in) && !$past(reset_in, 2)
    |-> health_sink_drive_out == !$past(hw_fail_in))
    else $error("health sink does not follow failure input");
  a_insync_perm: assert property (
    meas_valid_in && !sync_only_in &&
    gen_meas_in.freq >= utl_meas_in.freq + FREQ_WIN_DEFAULT
    |-> ##4 !in_sync_sink_drive_out)
    else $error("in sync with frequency apart");
  a_limit_sinks: assert property (
    output_limit_in |-> ##[1:3]
    (bias_limit_sink_drive_out && warning_sink_drive_out))
    else $error("output limit sinks not on");
  a_perm_avail: assert property (
    permissive_out && !sync_only_in |-> $past(both_ok))
    else $error("permissive without both sources");
  a_perm_drop: assert property (
    $fell(genset_ok_sink_drive_out) && !sync_only_in
    |-> ##1 !permissive_out)
    else $error("permissive not withdrawn at once");
  a_rot_block: assert property (
    meas_valid_in && gen_meas_in.rot != utl_meas_in.rot && !sync_only_in
    |-> ##4 !permissive_out)
    else $error("permissive with rotation mismatch");
  a_manual_sel: assert property (
    !manual_n_in [*5] |-> manual_mode_out)
    else $error("grounded mode pin not manual");
  a_auto_sel: assert property (
    manual_n_in [*5] |-> !manual_mode_out)
    else $error("open mode pin not auto");
  a_run_avail: assert property (
    sync_run_out |-> both_ok || $past(both_ok))
    else $error("running without both sources");
  a_run_manual: assert property (
    (!manual_n_in && sync_enable_n_in) [*6] |-> !sync_run_out)
    else $error("manual run without enable switch");
  c_perm: cover property ($rose(permissive_out));
  c_flash: cover property ($rose(flash_mode_out));
  c_run: cover property ($rose(sync_run_out));
endmodule : scs_sync_check_properties
bind scs_sync_check scs_sync_check_properties scs_sync_check_properties_i (.*);

// file: verification/scs_front_end.sv
// Bus sensing front end model that strobes sampled measurements
`timescale 1ns/1ps
module scs_front_end
  import scs_pkg::*;
(
  // Clock, reset and set values
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  input  wire scs_bus_s      gen_set_in,
  input  wire scs_bus_s      utl_set_in,
  input  wire logic [AW-1:0] phase_set_in,
  // Measurements
  output logic               meas_valid_out,
  output scs_bus_s           gen_out,
  output scs_bus_s           utl_out,
  output logic [AW-1:0]      phase_out
);
  logic [1:0] cnt;
  wire        load = cnt == 2'h3;
  // Data toggles outside the strobe, so stale use shows up
  always_ff @(posedge clock_in) begin
    cnt <= reset_in ? 2'h0 : cnt + 2'h1;
    meas_valid_out <= !reset_in && load;
    gen_out <= load ? gen_set_in : ~gen_out;
    utl_out <= load ? utl_set_in : ~utl_out;
    phase_out <= load ? phase_set_in : ~phase_out;
  end
endmodule : scs_front_end

// file: verification/scs_sync_check_test.sv
// Self-checking bench for the sync check block
`timescale 1ns/1ps
module scs_sync_check_test;
  import scs_pkg::*;
  typedef struct packed {
    logic [VW-1:0] gv;
    logic [FW-1:0] gf;
    logic          rot;
    logic [AW-1:0] ph;
    logic          p;
  } scs_row_s;
  logic          clock_in, reset_in, mv, sync_only, olim, hwf, frn, mn, sen;
  logic [2:0]    dead_en;
  logic [TW-1:0] fail_t;
  logic [AW-1:0] ph, phq;
  scs_bus_s      gset, uset, gq, uq;
  scs_sens_cfg_s cfg;
  logic          perm, run, flash, man, warn, sfail, gok, mok, insy, blim;
  logic          hlth;
  int            bad_count, compares;
  scs_row_s      rows [9] = '{'{12'h3e8, 16'h1770, 1'h0, 12'h000, 1'h1},
    '{12'h419, 16'h1770, 1'h0, 12'h000, 1'h1},
    '{12'h41a, 16'h1770, 1'h0, 12'h000, 1'h0},
    '{12'h3e8, 16'h17d3, 1'h0, 12'h000, 1'h1},
    '{12'h3e8, 16'h17d4, 1'h0, 12'h000, 1'h0},
    '{12'h3e8, 16'h1770, 1'h0, 12'h063, 1'h1},
    '{12'h3e8, 16'h1770, 1'h0, 12'h064, 1'h0},
    '{12'h3e8, 16'h1770, 1'h0, 12'hf9d, 1'h1},
    '{12'h3e8, 16'h1770, 1'h1, 12'h000, 1'h0}};
  scs_front_end scs_front_end_i (.clock_in(clock_in), .reset_in(reset_in),
    .gen_set_in(gset), .utl_set_in(uset), .phase_set_in(ph),
    .meas_valid_out(mv), .gen_out(gq), .utl_out(uq), .phase_out(phq));
  scs_sync_check scs_sync_check_i (.clock_in(clock_in), .reset_in(reset_in),
    .meas_valid_in(mv), .gen_meas_in(gq), .utl_meas_in(uq),
    .phase_diff_in(phq), .tick_div_in(17'h00001), .win_load_in(1'h0),
    .win_in('0), .gen_cfg_in(cfg), .utl_cfg_in(cfg), .sys_rot_in(1'h0),
    .sync_only_in(sync_only), .dead_en_in(dead_en), .fail_time_in(fail_t),
    .lockout_en_in(1'h0), .output_limit_in(olim), .hw_fail_in(hwf),
    .fault_reset_n_in(frn), .manual_n_in(mn), .sync_enable_n_in(sen),
    .permissive_out(perm), .sync_run_out(run), .flash_mode_out(flash),
    .manual_mode_out(man), .warning_sink_drive_out(warn),
    .sync_fail_sink_drive_out(sfail), .genset_ok_sink_drive_out(gok),
    .mains_ok_sink_drive_out(mok), .in_sync_sink_drive_out(insy),
    .bias_limit_sink_drive_out(blim), .health_sink_drive_out(hlth));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc
  task automatic chk(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    clock_in = 1'h0;
    forever #4 clock_in = ~clock_in;
  end
  // The run needs about 12k cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    compares = 0;
    reset_in = 1'h1;
    {sync_only, olim, hwf, dead_en} = '0;
    {frn, mn, sen} = 3'h7;
    fail_t = 16'hffff;
    ph = 12'h000;
    cfg = '{12'h384, 12'h3b6, 12'h44c, 12'h41a, 16'h16a8, 16'h1838,
      16'h170c, 16'h17d4, {4{16'h0008}}, 1'h1, 1'h1, 1'h0, 1'h1};
    gset = '{{3{12'h3e8}}, 16'h1770, 1'h0, {3{12'h4b0}}};
    uset = gset;
    cyc(2);
    chk("health", 1'h0, hlth);
    reset_in = 1'h0;
    foreach (rows[i]) begin
      gset.volt[2] = rows[i].gv;
      gset.freq = rows[i].gf;
      gset.rot = rows[i].rot;
      ph = rows[i].ph;
      cyc(520);
      chk("permissive", rows[i].p,
          perm);
      chk("in_sync", rows[i].p, insy);
    end
    gset.rot = 1'h0;
    cyc(300);
    gset.volt[2] = 12'h41a;
    cyc(8);
    gset.volt[2] = 12'h3e8;
    cyc(300);
    chk("permissive early", 1'h0, perm);
    cyc(220);
    chk("permissive", 1'h1, perm);
    gset.freq = 16'h17d4;
    cyc(9);
    chk("permissive drop", 1'h0, perm);
    gset.freq = 16'h1770;
    gset.volt = {3{12'h320}};
    cyc(6);
    chk("genset ok held", 1'h1, gok);
    cyc(14);
    chk("genset ok", 1'h0, gok);
    gset.volt = {3{12'h3e8}};
    cyc(9);
    chk("genset ok back", 1'h1, gok);
    chk("mains ok", 1'h1, mok);
    fail_t = 16'h000a;
    gset.freq = 16'h17d4;
    olim = 1'h1;
    cyc(40);
    chk("warning", 1'h1, warn);
    chk("sync fail", 1'h1, sfail);
    chk("bias limit", 1'h1, blim);
    olim = 1'h0;
    gset.freq = 16'h1770;
    fail_t = 16'hffff;
    cyc(520);
    frn = 1'h0;
    cyc(6);
    frn = 1'h1;
    cyc(6);
    chk("warning cleared", 1'h0, warn);
    chk("sync fail cleared", 1'h0, sfail);
    mn = 1'h0;
    cyc(8);
    chk("manual", 1'h1, man);
    chk("run off", 1'h0, run);
    sen = 1'h0;
    cyc(8);
    chk("run manual", 1'h1, run);
    {mn, sen} = 2'h3;
    cyc(8);
    chk("auto", 1'h0, man);
    chk("run auto", 1'h1, run);
    frn = 1'h0;
    cyc(4990);
    chk("flash early", 1'h0, flash);
    cyc(20);
    chk("flash", 1'h1, flash);
    frn = 1'h1;
    cyc(6);
    frn = 1'h0;
    cyc(6);
    frn = 1'h1;
    cyc(6);
    chk("flash left", 1'h0, flash);
    hwf = 1'h1;
    cyc(3);
    chk("health off", 1'h0, hlth);
    hwf = 1'h0;
    cyc(3);
    chk("health on", 1'h1, hlth);
    sync_only = 1'h1;
    dead_en = 3'h2;
    gset.volt = {3{12'h0f9}};
    cyc(540);
    chk("dead genset close", 1'h1, perm);
    gset.volt = {3{12'h0fa}};
    cyc(20);
    chk("not dead", 1'h0, perm);
    gset.volt = {3{12'h0f9}};
    dead_en = 3'h5;
    cyc(540);
    chk("scenario off", 1'h0, perm);
    end_sim();
  end
endmodule : scs_sync_check_test
